// ### word_push_pkg.sv
// constants, types and register map for the word push execution block
`default_nettype none
package word_push_pkg;

	// instruction encodings
	localparam logic [7:0]  OPC_PUSH_DISP   = 8'h27;
	localparam logic [7:0]  OPC_PUSH_DIRECT = 8'h67;
	localparam int          DISP_MARK_BIT   = 7;
	localparam int          DISP_WIDTH      = 7;
	localparam logic [15:0] LEN_PUSH_DISP   = 16'h0002;
	localparam logic [15:0] LEN_PUSH_DIRECT = 16'h0003;

	// special function register space and registers held here
	localparam logic [7:0]  SFR_PAGE        = 8'hFE;
	localparam logic [15:0] STACK_PTR_LOW_ADDR  = 16'hFE0A;
	localparam logic [15:0] STACK_PTR_HIGH_ADDR = 16'hFE0B;
	localparam logic [15:0] PSW_ADDR        = 16'hFE06;
	localparam int          PARITY_FLAG_BIT = 1;

	// values after reset
	localparam logic [15:0] STACK_PTR_RESET = 16'h0000;
	localparam logic [7:0]  PSW_RESET       = 8'h00;

	// stack step per byte and cycles of one push
	localparam logic [15:0] STACK_STEP      = 16'h0001;
	localparam int          PUSH_CYCLES     = 3;

	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0001,
		ST_FETCH  = 4'b0010,
		ST_STORE  = 4'b0100,
		ST_FINISH = 4'b1000
	} push_state_e;

	// instruction bytes in fetch order, byte0 is the opcode
	typedef struct packed {
		logic [7:0] byte2;
		logic [7:0] byte1;
		logic [7:0] byte0;
	} inst_bytes_s;

	// 9-bit byte pair, lower address holds the low byte
	typedef struct packed {
		logic [8:0] hi;
		logic [8:0] lo;
	} word9_s;

	// result of decoding one instruction
	typedef struct packed {
		logic        is_push;
		logic        is_direct;
		logic [15:0] src_addr;
		logic [15:0] length;
		logic        from_sfr;
	} decode_s;

endpackage : word_push_pkg
`default_nettype wire

// ### push_decoder.sv
// opcode decode and operand address forming for both word push forms
`timescale 1ns/1ps
`default_nettype none
module push_decoder (
	input  wire logic                      [15:0] indirect_zero,
	input  wire word_push_pkg::inst_bytes_s       inst,
	output var  word_push_pkg::decode_s           dec
);
	import word_push_pkg::*;

	logic [15:0] disp_ext;

	always_comb begin
		disp_ext = {{(16 - DISP_WIDTH){inst.byte1[DISP_WIDTH-1]}}, inst.byte1[DISP_WIDTH-1:0]};
		dec = '0;
		if (inst.byte0 == OPC_PUSH_DISP && inst.byte1[DISP_MARK_BIT]) begin
			dec.is_push  = 1'b1;
			dec.src_addr = indirect_zero + disp_ext;
			dec.length   = LEN_PUSH_DISP;
		end else if (inst.byte0 == OPC_PUSH_DIRECT) begin
			dec.is_push   = 1'b1;
			dec.is_direct = 1'b1;
			dec.src_addr  = {inst.byte2, inst.byte1};
			dec.length    = LEN_PUSH_DIRECT;
		end
		// the special function page is fetched from the register side, all else from ram
		dec.from_sfr = (dec.src_addr[15:8] == SFR_PAGE);
	end

endmodule : push_decoder
`default_nettype wire

// ### word_router.sv
// picks the fetched word from ram or register space and derives the stack word
`timescale 1ns/1ps
`default_nettype none
module word_router (
	input  wire logic                  from_sfr,
	input  wire word_push_pkg::word9_s mem_word,
	input  wire word_push_pkg::word9_s sfr_word,
	output var  word_push_pkg::word9_s stack_word,
	output logic                       upper_ninth
);
	import word_push_pkg::*;

	always_comb begin
		stack_word = from_sfr ? sfr_word : mem_word;
		// both ninth bits travel unchanged into the stack copy
		upper_ninth = stack_word.hi[8];
	end

endmodule : word_router
`default_nettype wire

// ### word_push_exec.sv
// execution logic for the displacement and direct word push instructions
//
// Function
// - displacement form: byte 27h, then byte with top bit set and offset.
// - operand address is indirect register zero plus sign-extended 7-bit offset.
// - displacement form takes 3 cycles and advances program counter by 2.
// - stack pointer pre-increments, word written there, increments again: net two.
// - operand word comes from data memory or special function register.
// - upper source ninth bit goes to parity flag and upper stack ninth bit.
// - lower source ninth bit copies unchanged into lower stack ninth bit.
// - opcode 67h is a three-byte direct push, address low byte first.
// - direct form takes 3 cycles and advances program counter by 3.
// - stack pointer low at FE0Ah, high at FE0Bh, grows upward.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module word_push_exec (
	input  wire logic                      CLOCK,
	input  wire logic                      RESET_N,
	// instruction issue from the core
	input  wire logic                      INST_VALID,
	input  wire word_push_pkg::inst_bytes_s INST_BYTES,
	input  wire logic               [15:0] PC_IN,
	input  wire logic               [15:0] INDIRECT_ZERO,
	output logic                           INST_READY,
	output logic                           DONE,
	output logic                           ILLEGAL,
	output logic                    [15:0] PC_OUT,
	output logic                           PC_LOAD,
	// data memory, word wide, read data one cycle after the strobe
	output logic                           MEM_RD,
	output logic                    [15:0] MEM_RADDR,
	input  wire word_push_pkg::word9_s      MEM_RDATA,
	output logic                           MEM_WR,
	output logic                    [15:0] MEM_WADDR,
	output word_push_pkg::word9_s          MEM_WDATA,
	// special function register space, read data one cycle after the strobe
	output logic                           SFR_RD,
	output logic                    [15:0] SFR_RADDR,
	input  wire word_push_pkg::word9_s      SFR_RDATA,
	// register port
	input  wire logic               [15:0] REG_ADDR,
	input  wire logic                [7:0] REG_WDATA,
	input  wire logic                      REG_WR,
	input  wire logic                      REG_RD,
	output logic                     [7:0] REG_RDATA,
	output logic                           PARITY_FLAG
);
	import word_push_pkg::*;

	////////////////////////////////////////////////////////////////////////////////

	typedef struct packed {
		push_state_e st;
		logic [15:0] stack_ptr;
		logic [7:0]  program_status_word;
		logic [15:0] pc_base;
		logic [15:0] length;
		logic [15:0] src_addr;
		logic        from_sfr;
		logic        mem_rd;
		logic        sfr_rd;
		logic        mem_wr;
		logic [15:0] waddr;
		word9_s      wdata;
		logic        done;
		logic        illegal;
		logic        pc_load;
		logic [15:0] pc_out;
		logic [7:0]  rdata;
	} exec_s;

	exec_s   cur_r;
	exec_s   cur_nxt;
	decode_s dec;
	word9_s  stack_word;
	logic    upper_ninth;
	logic    accept;

	////////////////////////////////////////////////////////////////////////////////

	push_decoder u_decoder (
		.indirect_zero (INDIRECT_ZERO),
		.inst          (INST_BYTES),
		.dec           (dec)
	);

	word_router u_router (
		.from_sfr    (cur_r.from_sfr),
		.mem_word    (MEM_RDATA),
		.sfr_word    (SFR_RDATA),
		.stack_word  (stack_word),
		.upper_ninth (upper_ninth)
	);

	////////////////////////////////////////////////////////////////////////////////

	assign INST_READY = (cur_r.st == ST_IDLE);
	assign accept     = INST_READY && INST_VALID;

	always_comb begin
		cur_nxt = cur_r;
		// one-cycle pulses fall back every cycle
		cur_nxt.mem_rd  = 1'b0;
		cur_nxt.sfr_rd  = 1'b0;
		cur_nxt.mem_wr  = 1'b0;
		cur_nxt.done    = 1'b0;
		cur_nxt.illegal = 1'b0;
		cur_nxt.pc_load = 1'b0;
		cur_nxt.rdata   = 8'h00;

		// register reads answer one cycle later; unmapped addresses read zero
		if (REG_RD) begin
			case (REG_ADDR)
				STACK_PTR_LOW_ADDR:  cur_nxt.rdata = cur_r.stack_ptr[7:0];
				STACK_PTR_HIGH_ADDR: cur_nxt.rdata = cur_r.stack_ptr[15:8];
				PSW_ADDR:            cur_nxt.rdata = cur_r.program_status_word;
				default:             cur_nxt.rdata = 8'h00;
			endcase
		end

		// software writes land only while idle so a push never sees a torn pointer
		if (REG_WR && cur_r.st == ST_IDLE && !INST_VALID) begin
			case (REG_ADDR)
				STACK_PTR_LOW_ADDR:  cur_nxt.stack_ptr[7:0]  = REG_WDATA;
				STACK_PTR_HIGH_ADDR: cur_nxt.stack_ptr[15:8] = REG_WDATA;
				PSW_ADDR:            cur_nxt.program_status_word             = REG_WDATA;
				default:             cur_nxt.program_status_word             = cur_r.program_status_word;
			endcase
		end

		case (cur_r.st)
			ST_IDLE: begin
				if (accept) begin
					if (dec.is_push) begin
						cur_nxt.st       = ST_FETCH;
						cur_nxt.pc_base  = PC_IN;
						cur_nxt.length   = dec.length;
						cur_nxt.src_addr = dec.src_addr;
						cur_nxt.from_sfr = dec.from_sfr;
						// fetch the whole word in one access, low byte at src_addr
						cur_nxt.mem_rd   = !dec.from_sfr;
						cur_nxt.sfr_rd   = dec.from_sfr;
					end else begin
						cur_nxt.illegal  = 1'b1;
					end
				end
			end
			ST_FETCH: begin
				// read data stands on the selected port during the next cycle
				cur_nxt.st = ST_STORE;
			end
			ST_STORE: begin
				cur_nxt.st        = ST_FINISH;
				cur_nxt.stack_ptr = cur_r.stack_ptr + STACK_STEP;
				cur_nxt.mem_wr    = 1'b1;
				// word goes to the pre-incremented pointer, low byte at the lower address
				cur_nxt.waddr     = cur_r.stack_ptr + STACK_STEP;
				cur_nxt.wdata.hi  = stack_word.hi;
				cur_nxt.wdata.lo  = stack_word.lo;
				cur_nxt.program_status_word[PARITY_FLAG_BIT] = upper_ninth;
			end
			ST_FINISH: begin
				cur_nxt.st        = ST_IDLE;
				cur_nxt.stack_ptr = cur_r.stack_ptr + STACK_STEP;
				cur_nxt.done      = 1'b1;
				cur_nxt.pc_load   = 1'b1;
				cur_nxt.pc_out    = cur_r.pc_base + cur_r.length;
			end
			default: begin
				cur_nxt.st = ST_IDLE;
			end
		endcase
	end

	// pushing the pointer itself reads the pre-push value; no guard is built here
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			cur_r           <= '0;
			cur_r.st        <= ST_IDLE;
			cur_r.stack_ptr <= STACK_PTR_RESET;
			cur_r.program_status_word       <= PSW_RESET;
		end else begin
			cur_r <= cur_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	assign DONE        = cur_r.done;
	assign ILLEGAL     = cur_r.illegal;
	assign PC_OUT      = cur_r.pc_out;
	assign PC_LOAD     = cur_r.pc_load;
	assign MEM_RD      = cur_r.mem_rd;
	assign MEM_RADDR   = cur_r.src_addr;
	assign SFR_RD      = cur_r.sfr_rd;
	assign SFR_RADDR   = cur_r.src_addr;
	assign MEM_WR      = cur_r.mem_wr;
	assign MEM_WADDR   = cur_r.waddr;
	assign MEM_WDATA   = cur_r.wdata;
	assign REG_RDATA   = cur_r.rdata;
	assign PARITY_FLAG = cur_r.program_status_word[PARITY_FLAG_BIT];

endmodule : word_push_exec
`default_nettype wire

// ### push_chk_sva.sv
// assertions on the ports of the word push execution block
`timescale 1ns/1ps
`default_nettype none
module push_chk (
	input wire logic                       CLOCK,
	input wire logic                       RESET_N,
	input wire logic                       INST_VALID,
	input wire logic                       INST_READY,
	input wire word_push_pkg::inst_bytes_s INST_BYTES,
	input wire logic                [15:0] PC_IN,
	input wire logic                [15:0] INDIRECT_ZERO,
	input wire logic                       DONE,
	input wire logic                       ILLEGAL,
	input wire logic                       PC_LOAD,
	input wire logic                       MEM_WR,
	input wire logic                [15:0] MEM_RADDR,
	input wire logic                [15:0] PC_OUT,
	input wire word_push_pkg::word9_s      MEM_WDATA,
	input wire logic                       PARITY_FLAG
);
	import word_push_pkg::*;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RESET_N);
	wire logic        tk  = INST_VALID && INST_READY;
	wire logic        dsp = INST_BYTES.byte0 == OPC_PUSH_DISP && INST_BYTES.byte1[7];
	wire logic        dir = INST_BYTES.byte0 == OPC_PUSH_DIRECT;
	wire logic [15:0] dad = INDIRECT_ZERO + {{9{INST_BYTES.byte1[6]}}, INST_BYTES.byte1[6:0]};
	wire logic [15:0] rad = {INST_BYTES.byte2, INST_BYTES.byte1};
	wire logic [15:0] pcn = PC_IN + (dir ? LEN_PUSH_DIRECT : LEN_PUSH_DISP);
	sequence push_take; tk && (dsp || dir); endsequence
	// the stack write lands one cycle before the completion pulse
	sequence store_step; MEM_WR && !DONE; endsequence
	sequence finish; DONE && PC_LOAD && !MEM_WR; endsequence
	done_in_three_a: assert property (push_take |=> !DONE [*2] ##1 store_step ##1 finish)
		else $error("push end misplaced");
	busy_hold_a: assert property (push_take |=> !INST_READY [*3] ##1 INST_READY)
		else $error("ready during push");
	bad_code_a: assert property (tk && !(dsp || dir) |=> ILLEGAL && !MEM_WR)
		else $error("illegal code not flagged");
	disp_addr_a: assert property (tk && dsp |=> MEM_RADDR == $past(dad))
		else $error("wrong offset address");
	direct_addr_a: assert property (tk && dir && rad[15:8] != SFR_PAGE |=> MEM_RADDR == $past(rad))
		else $error("wrong direct address");
	pc_step_a: assert property (push_take |-> ##4 PC_OUT == $past(pcn, 4))
		else $error("wrong pc advance");
	parity_copy_a: assert property (DONE |-> PARITY_FLAG == MEM_WDATA.hi[8])
		else $error("parity flag differs");
	pc_hold_a: assert property (!PC_LOAD |-> $stable(PC_OUT))
		else $error("pc moved without load");
endmodule : push_chk
bind word_push_exec push_chk chk_u (.CLOCK, .RESET_N, .INST_VALID, .INST_READY, .INST_BYTES,
	.PC_IN, .INDIRECT_ZERO, .DONE, .ILLEGAL, .PC_LOAD, .MEM_WR, .MEM_RADDR, .PC_OUT,
	.MEM_WDATA, .PARITY_FLAG);
`default_nettype wire

// ### mem_model.sv
// data memory and register space answering the push block
`timescale 1ns/1ps
`default_nettype none
module mem_model (
	input  wire logic                  CLOCK,
	input  wire logic                  MEM_RD,
	input  wire logic           [15:0] MEM_RADDR,
	output var  word_push_pkg::word9_s MEM_RDATA,
	input  wire logic                  MEM_WR,
	input  wire logic           [15:0] MEM_WADDR,
	input  wire word_push_pkg::word9_s MEM_WDATA,
	input  wire logic                  SFR_RD,
	input  wire logic           [15:0] SFR_RADDR,
	output var  word_push_pkg::word9_s SFR_RDATA
);
	import word_push_pkg::*;
	word9_s ram [0:255];
	word9_s special_function_register [0:255];
	word9_s mq, sq;
	logic   mv = 1'b0;
	logic   sv = 1'b0;
	// one entry holds the low byte at the address and the high byte above it
	always @(posedge CLOCK) begin
		mv <= MEM_RD;
		sv <= SFR_RD;
		if (MEM_RD) mq <= ram[MEM_RADDR[7:0]];
		if (SFR_RD) sq <= special_function_register[SFR_RADDR[7:0]];
		if (MEM_WR) ram[MEM_WADDR[7:0]] <= MEM_WDATA;
	end
	// outside the answer cycle the bus shows garbage, so a late sample is caught
	assign MEM_RDATA = mv ? mq : ~mq;
	assign SFR_RDATA = sv ? sq : ~sq;
endmodule : mem_model
`default_nettype wire

// ### testbench.sv
// self-checking bench for the word push execution block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import word_push_pkg::*;
	logic        CLOCK = 1'b0, RESET_N = 1'b0, INST_VALID = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0;
	inst_bytes_s INST_BYTES = '0;
	logic [15:0] PC_IN = '0, INDIRECT_ZERO = '0, REG_ADDR = '0, sp;
	logic  [7:0] REG_WDATA = '0, rd;
	wire logic   INST_READY, DONE, ILLEGAL, PC_LOAD, MEM_RD, MEM_WR, SFR_RD, PARITY_FLAG;
	wire logic [15:0] PC_OUT, MEM_RADDR, MEM_WADDR, SFR_RADDR;
	wire logic  [7:0] REG_RDATA;
	wire word9_s MEM_RDATA, MEM_WDATA, SFR_RDATA;
	int          n_fail = 0, check_count = 0;
	word_push_exec dut_u (.CLOCK, .RESET_N, .INST_VALID, .INST_BYTES, .PC_IN, .INDIRECT_ZERO,
		.INST_READY, .DONE, .ILLEGAL, .PC_OUT, .PC_LOAD, .MEM_RD, .MEM_RADDR, .MEM_RDATA,
		.MEM_WR, .MEM_WADDR, .MEM_WDATA, .SFR_RD, .SFR_RADDR, .SFR_RDATA, .REG_ADDR,
		.REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .PARITY_FLAG);
	mem_model model_u (.CLOCK, .MEM_RD, .MEM_RADDR, .MEM_RDATA, .MEM_WR, .MEM_WADDR,
		.MEM_WDATA, .SFR_RD, .SFR_RADDR, .SFR_RDATA);
	initial forever #2 CLOCK = ~CLOCK;
	////////////////////////////////////////////////////////////////////////
	task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : summarize
	task automatic reg_io(logic wr, logic [15:0] a, logic [7:0] d);
		@(posedge CLOCK);
		REG_ADDR  <= a;
		REG_WDATA <= d;
		REG_WR    <= wr;
		REG_RD    <= !wr;
		@(posedge CLOCK);
		REG_WR <= 1'b0;
		REG_RD <= 1'b0;
		#1 rd = REG_RDATA;
	endtask : reg_io
	task automatic sp_chk;
		reg_io(1'b0, STACK_PTR_LOW_ADDR, 8'h00);
		chk("sp low", rd, sp[7:0]);
		reg_io(1'b0, STACK_PTR_HIGH_ADDR, 8'h00);
		chk("sp high", rd, sp[15:8]);
	endtask : sp_chk
	////////////////////////////////////////////////////////////////////////
	// operands never resolve to the stack pointer itself
	task automatic push(logic [23:0] ib, logic [15:0] r0, logic [15:0] adr, word9_s w);
		int   n;
		logic sfr_src;
		sfr_src = (adr[15:8] == SFR_PAGE);
		if (sfr_src) model_u.special_function_register[adr[7:0]] = w;
		else model_u.ram[adr[7:0]] = w;
		@(posedge CLOCK);
		INST_BYTES    <= ib;
		INST_VALID    <= 1'b1;
		PC_IN         <= 16'h0100;
		INDIRECT_ZERO <= r0;
		@(posedge CLOCK);
		INST_VALID <= 1'b0;
		#1 n = 0;
		chk("busy", INST_READY, 1'b0);
		chk("read strobes", {MEM_RD, SFR_RD}, sfr_src ? 2'b01 : 2'b10);
		chk("read addr", sfr_src ? SFR_RADDR : MEM_RADDR, adr);
		while (DONE !== 1'b1 && n < 9) begin
			@(posedge CLOCK);
			#1 n++;
		end
		chk("cycles", n, PUSH_CYCLES);
		chk("pc load", PC_LOAD, 1'b1);
		chk("ready again", INST_READY, 1'b1);
		chk("stack addr", MEM_WADDR, sp + 16'h0001);
		chk("stack word", MEM_WDATA, w);
		chk("parity", PARITY_FLAG, w.hi[8]);
		chk("pc", PC_OUT, 16'h0100 + (ib[7:0] == 8'h67 ? 16'h0003 : 16'h0002));
		sp = sp + 16'h0002;
		sp_chk();
		chk("stored", model_u.ram[sp[7:0] - 8'h01], w);
		reg_io(1'b0, PSW_ADDR, 8'h00);
		chk("psw parity", rd[PARITY_FLAG_BIT], w.hi[8]);
		if (n == 9) summarize();
	endtask : push
	task automatic bad(logic [23:0] ib);
		@(posedge CLOCK);
		INST_BYTES <= ib;
		INST_VALID <= 1'b1;
		@(posedge CLOCK);
		INST_VALID <= 1'b0;
		#1 chk("illegal", ILLEGAL, 1'b1);
		chk("no read", MEM_RD | SFR_RD, 1'b0);
	endtask : bad
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge CLOCK);
		RESET_N <= 1'b1;
		sp = STACK_PTR_RESET;
		sp_chk();
		reg_io(1'b0, 16'hFE00, 8'h00);
		chk("unmapped", rd, 8'h00);
		reg_io(1'b1, STACK_PTR_LOW_ADDR, 8'hC7);
		reg_io(1'b1, STACK_PTR_HIGH_ADDR, 8'h00);
		sp = 16'h00C7;
		sp_chk();
		push(24'h008427, 16'h0051, 16'h0055, {9'h112, 9'h034});
		push(24'h00C027, 16'h0100, 16'h00C0, {9'h034, 9'h112});
		push(24'h00C067, 16'h0051, 16'h00C0, {9'h112, 9'h112});
		push(24'hFE2067, 16'h0051, 16'hFE20, {9'h0AB, 9'h1CD});
		bad(24'h000427);
		bad(24'h008426);
		summarize();
	end
	initial begin
		#100000;
		n_fail++;
		summarize();
	end
endmodule : testbench
`default_nettype wire
